// ===== design/scb_pkg.sv
package scb_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned SCB_CLOCK_HZ = 125000000;
    localparam int unsigned SCB_MAX_RATE_HZ = 1250000;
    // shortest sample spacing, rounded up to whole cycles
    localparam logic [31:0] SCB_MIN_PERIOD =
        32'((SCB_CLOCK_HZ + SCB_MAX_RATE_HZ - 1) / SCB_MAX_RATE_HZ);
    localparam logic [4:0] SCB_RATE_EXP_MAX = 5'd20;

    // ************************************************************
    // buffer geometry
    // ************************************************************
    localparam int SCB_VALUE_W = 32;
    localparam int SCB_VALUE_BYTES = 4;
    localparam int SCB_BLOCK_BYTES = 2048;
    localparam int SCB_BLOCK_VALUES = SCB_BLOCK_BYTES / SCB_VALUE_BYTES;
    localparam int SCB_BLOCK_W = $clog2(SCB_BLOCK_VALUES);
    localparam int SCB_KB_SHIFT = $clog2(1024 / SCB_VALUE_BYTES);
    localparam int SCB_MEM_WORDS = 1048576;
    localparam int SCB_IDX_W = 20;
    localparam int SCB_PTR_W = 21;
    localparam int SCB_LEN_W = 13;
    localparam logic [12:0] SCB_LEN_MIN = 13'd2;
    localparam logic [12:0] SCB_LEN_MAX = 13'd4096;
    localparam logic [12:0] SCB_LEN_RESET = 13'd2;

    // ************************************************************
    // register map and fields
    // ************************************************************
    localparam int SCB_ADDR_W = 8;
    localparam logic [7:0] SCB_OFS_CTRL = 8'h00;
    localparam logic [7:0] SCB_OFS_CFG = 8'h04;
    localparam logic [7:0] SCB_OFS_RATE = 8'h08;
    localparam logic [7:0] SCB_OFS_TCPER = 8'h0c;
    localparam logic [7:0] SCB_OFS_STAT = 8'h10;
    localparam logic [7:0] SCB_OFS_PROG = 8'h14;
    localparam logic [7:0] SCB_OFS_RDIDX = 8'h18;
    localparam logic [7:0] SCB_OFS_RDDATA = 8'h1c;
    localparam int SCB_CTRL_LAUNCH = 0;
    localparam int SCB_CTRL_MODE = 1;
    localparam int SCB_CTRL_TRIG = 2;
    localparam int SCB_CTRL_HALT = 3;
    localparam int SCB_CFG_SEL_LSB = 16;
    localparam logic [1:0] SCB_SEL_X = 2'h0;
    localparam logic [1:0] SCB_SEL_XY = 2'h1;
    localparam logic [1:0] SCB_SEL_RT = 2'h2;
    localparam logic [1:0] SCB_SEL_XYRT = 2'h3;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {PH_IDLE, PH_ARMED, PH_RUN, PH_DRAIN} scb_phase_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [SCB_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } scb_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } scb_apb_rsp_s;

    typedef struct packed {
        logic [SCB_VALUE_W-1:0] x;
        logic [SCB_VALUE_W-1:0] y;
        logic [SCB_VALUE_W-1:0] r;
        logic [SCB_VALUE_W-1:0] theta;
    } scb_sample_s;

    typedef struct packed {
        scb_phase_e phase;
        logic contMode;
        logic trigArmed;
        logic triggered;
        logic wrapped;
        logic trigPrev;
        logic [SCB_LEN_W-1:0] lenKb;
        logic [1:0] paramSel;
        logic [4:0] rateExp;
        logic [31:0] tcPeriod;
        logic [31:0] cnt;
        logic [3:0][SCB_VALUE_W-1:0] hold;
        logic [2:0] holdCount;
        logic [1:0] holdIdx;
        logic [SCB_PTR_W-1:0] ptr;
        logic [SCB_IDX_W-1:0] rdIdx;
        scb_apb_rsp_s rsp;
    } scb_state_s;

    localparam scb_state_s SCB_STATE_RESET = '{
        phase: PH_IDLE,
        lenKb: SCB_LEN_RESET,
        tcPeriod: SCB_MIN_PERIOD,
        trigPrev: 1'b1,
        default: '0
    };

endpackage

// ===== design/scb_store.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// capture storage, one write port and one read port
// ************************************************************
module scb_store
#(
    parameter int WORDS = scb_pkg::SCB_MEM_WORDS,
    parameter int AW = scb_pkg::SCB_IDX_W
)
(
    input wire logic clock,
    input wire logic writeEn,
    input wire logic [AW-1:0] writeAddr,
    input wire logic [scb_pkg::SCB_VALUE_W-1:0] writeData,
    input wire logic [AW-1:0] readAddr,
    output logic [scb_pkg::SCB_VALUE_W-1:0] readData
);
    import scb_pkg::*;

    logic [SCB_VALUE_W-1:0] mem [WORDS];

    // contents are not reset; a new capture overwrites them anyway
    always_ff @(posedge clock)
    begin
        if (writeEn)
        begin
            mem[writeAddr] <= writeData;
        end
    end

    // asynchronous read so the bus can answer from the setup cycle
    assign readData = mem[readAddr];

endmodule

`default_nettype wire

// ===== design/scb_sample_capture_buffer.sv
`timescale 1ns/1ps
`default_nettype none

module scb_sample_capture_buffer
(
    input wire logic clock,
    input wire logic rst_n,
    input wire scb_pkg::scb_apb_req_s apbReq,
    output var scb_pkg::scb_apb_rsp_s apbRsp,
    input wire scb_pkg::scb_sample_s demodSample,
    input wire logic externalTriggerInput
);
    import scb_pkg::*;

    scb_state_s s;
    scb_state_s next_s;

    logic memWrite;
    logic [SCB_IDX_W-1:0] memWrAddr;
    logic [SCB_VALUE_W-1:0] memWrData;
    logic [SCB_VALUE_W-1:0] memRdData;

    logic trigFall;
    logic trigRise;
    logic apbSetup;
    logic apbDone;
    logic recording;
    logic acquisitionLaunchCmd;
    logic acquisitionHaltCmd;
    logic captureReset;
    logic stopRequest;
    logic sampleTick;
    logic [31:0] basePeriod;
    logic [31:0] period;
    logic [SCB_PTR_W-1:0] endWords;
    logic [SCB_PTR_W-1:0] ptrInc;
    logic [SCB_LEN_W-1:0] progKb;

    // ************************************************************
    // helpers
    // ************************************************************

    // odd lengths round up, out of range lengths clamp
    function automatic logic [SCB_LEN_W-1:0] norm_len(input logic [15:0] raw);
        logic [SCB_LEN_W-1:0] v;
        if (raw == 16'h0000)
        begin
            v = SCB_LEN_MIN;
        end
        else if (raw > 16'(SCB_LEN_MAX))
        begin
            v = SCB_LEN_MAX;
        end
        else
        begin
            v = raw[SCB_LEN_W-1:0];
        end
        if (v[0])
        begin
            v = v + SCB_LEN_W'(1);
        end
        return v;
    endfunction

    // ************************************************************
    // storage
    // ************************************************************

    // one word per value, bus lanes little endian by nature
    scb_store #(
        .WORDS(SCB_MEM_WORDS),
        .AW(SCB_IDX_W)
    ) store (
        .clock(clock),
        .writeEn(memWrite),
        .writeAddr(memWrAddr),
        .writeData(memWrData),
        .readAddr(s.rdIdx),
        .readData(memRdData)
    );

    // write port driven from the pending sample words
    always_comb
    begin
        recording = (s.phase == PH_RUN) || (s.phase == PH_DRAIN);
        memWrite = recording && (s.holdCount != 3'h0);
        memWrAddr = s.ptr[SCB_IDX_W-1:0];
        memWrData = s.hold[s.holdIdx];
    end

    // ************************************************************
    // derived values
    // ************************************************************

    // spacing re-evaluated every cycle, so a new time constant bites at once
    always_comb
    begin
        if (s.tcPeriod < SCB_MIN_PERIOD)
        begin
            basePeriod = SCB_MIN_PERIOD;
        end
        else
        begin
            basePeriod = s.tcPeriod;
        end
        period = basePeriod << s.rateExp;
        sampleTick = recording && (s.cnt >= period - 32'h00000001);
        endWords = {s.lenKb, SCB_KB_SHIFT'(0)};
        ptrInc = s.ptr + SCB_PTR_W'(1);
        progKb = s.wrapped ? s.lenKb : s.ptr[SCB_PTR_W-1:SCB_KB_SHIFT];
        trigFall = s.trigPrev && !externalTriggerInput;
        trigRise = !s.trigPrev && externalTriggerInput;
        apbSetup = apbReq.psel && !apbReq.penable;
        apbDone = apbReq.psel && apbReq.penable && s.rsp.pready;
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        next_s = s;
        acquisitionLaunchCmd = 1'b0;
        acquisitionHaltCmd = 1'b0;
        captureReset = 1'b0;
        stopRequest = 1'b0;
        next_s.trigPrev = externalTriggerInput;

        // bus answer prepared in the setup cycle, ready in the first access
        next_s.rsp.pready = apbSetup;
        if (apbSetup)
        begin
            next_s.rsp.pslverr = 1'b0;
            case (apbReq.paddr)
                SCB_OFS_CTRL: next_s.rsp.prdata = 32'h00000000;
                SCB_OFS_CFG: next_s.rsp.prdata = {14'h0000, s.paramSel, 3'h0, s.lenKb};
                SCB_OFS_RATE: next_s.rsp.prdata = {27'h0000000, s.rateExp};
                SCB_OFS_TCPER: next_s.rsp.prdata = s.tcPeriod;
                SCB_OFS_STAT:
                    next_s.rsp.prdata = {29'h00000000, s.wrapped, s.triggered, recording};
                SCB_OFS_PROG: next_s.rsp.prdata = {19'h00000, progKb};
                SCB_OFS_RDIDX: next_s.rsp.prdata = {12'h000, s.rdIdx};
                SCB_OFS_RDDATA:
                begin
                    // contents are only meaningful once acquisition is over
                    if (s.phase == PH_IDLE)
                    begin
                        next_s.rsp.prdata = memRdData;
                    end
                    else
                    begin
                        next_s.rsp.prdata = 32'h00000000;
                        next_s.rsp.pslverr = 1'b1;
                    end
                end
                default:
                begin
                    next_s.rsp.prdata = 32'h00000000;
                    next_s.rsp.pslverr = 1'b1;
                end
            endcase
        end

        // register writes take effect at the completing edge only
        if (apbDone && apbReq.pwrite && !s.rsp.pslverr)
        begin
            case (apbReq.paddr)
                SCB_OFS_CTRL:
                begin
                    acquisitionLaunchCmd = apbReq.pwdata[SCB_CTRL_LAUNCH];
                    acquisitionHaltCmd = apbReq.pwdata[SCB_CTRL_HALT];
                end
                SCB_OFS_CFG:
                begin
                    next_s.lenKb = norm_len(apbReq.pwdata[15:0]);
                    next_s.paramSel = apbReq.pwdata[SCB_CFG_SEL_LSB +: 2];
                    captureReset = 1'b1;
                end
                SCB_OFS_RATE:
                begin
                    if (apbReq.pwdata[4:0] > SCB_RATE_EXP_MAX)
                    begin
                        next_s.rateExp = SCB_RATE_EXP_MAX;
                    end
                    else
                    begin
                        next_s.rateExp = apbReq.pwdata[4:0];
                    end
                end
                SCB_OFS_TCPER: next_s.tcPeriod = apbReq.pwdata;
                SCB_OFS_RDIDX: next_s.rdIdx = apbReq.pwdata[SCB_IDX_W-1:0];
                default:
                begin
                end
            endcase
        end

        // each data read that is not refused steps to the next word
        if (apbDone && !apbReq.pwrite && !s.rsp.pslverr && (apbReq.paddr == SCB_OFS_RDDATA))
        begin
            next_s.rdIdx = s.rdIdx + SCB_IDX_W'(1);
        end

        // capture engine
        case (s.phase)
            PH_IDLE:
            begin
            end
            PH_ARMED:
            begin
                if (trigFall)
                begin
                    next_s.phase = PH_RUN;
                    next_s.triggered = 1'b1;
                    next_s.cnt = 32'h00000000;
                end
            end
            PH_RUN, PH_DRAIN:
            begin
                // sample clock keeps running while words are written
                if (sampleTick)
                begin
                    next_s.cnt = 32'h00000000;
                end
                else
                begin
                    next_s.cnt = s.cnt + 32'h00000001;
                end

                if (s.holdCount != 3'h0)
                begin
                    next_s.holdCount = s.holdCount - 3'h1;
                    next_s.holdIdx = s.holdIdx + 2'h1;
                    if (ptrInc == endWords)
                    begin
                        next_s.ptr = '0;
                        next_s.wrapped = 1'b1;
                        if (!s.contMode)
                        begin
                            next_s.phase = PH_IDLE;
                        end
                    end
                    else
                    begin
                        next_s.ptr = ptrInc;
                    end
                end
                else if ((s.phase == PH_DRAIN) && (s.ptr[SCB_BLOCK_W-1:0] == '0))
                begin
                    // block boundary reached with nothing pending
                    next_s.phase = PH_IDLE;
                end
                else if (sampleTick)
                begin
                    // every selected parameter latched on the same edge
                    next_s.holdIdx = 2'h0;
                    next_s.hold[0] = demodSample.x;
                    next_s.hold[1] = demodSample.y;
                    next_s.hold[2] = demodSample.r;
                    next_s.hold[3] = demodSample.theta;
                    case (s.paramSel)
                        SCB_SEL_X: next_s.holdCount = 3'h1;
                        SCB_SEL_XY: next_s.holdCount = 3'h2;
                        SCB_SEL_RT:
                        begin
                            next_s.hold[0] = demodSample.r;
                            next_s.hold[1] = demodSample.theta;
                            next_s.holdCount = 3'h2;
                        end
                        default: next_s.holdCount = 3'h4;
                    endcase
                end
            end
            default:
            begin
                next_s.phase = PH_IDLE;
            end
        endcase

        // stop by command, or by trigger release in continuous triggered mode
        stopRequest = acquisitionHaltCmd ||
            (trigRise && s.contMode && s.trigArmed && (s.phase == PH_RUN));
        if (stopRequest)
        begin
            if (next_s.phase == PH_ARMED)
            begin
                next_s.phase = PH_IDLE;
            end
            else if (next_s.phase == PH_RUN)
            begin
                next_s.phase = PH_DRAIN;
            end
        end

        // launch wins over a halt carried in the same write
        if (acquisitionLaunchCmd)
        begin
            next_s.contMode = apbReq.pwdata[SCB_CTRL_MODE];
            next_s.trigArmed = apbReq.pwdata[SCB_CTRL_TRIG];
            next_s.phase = apbReq.pwdata[SCB_CTRL_TRIG] ? PH_ARMED : PH_RUN;
            next_s.triggered = !apbReq.pwdata[SCB_CTRL_TRIG];
            next_s.wrapped = 1'b0;
            next_s.ptr = '0;
            next_s.holdCount = 3'h0;
            next_s.holdIdx = 2'h0;
            next_s.cnt = 32'h00000000;
        end

        // new geometry invalidates any capture in flight
        if (captureReset)
        begin
            next_s.phase = PH_IDLE;
            next_s.triggered = 1'b0;
            next_s.wrapped = 1'b0;
            next_s.ptr = '0;
            next_s.holdCount = 3'h0;
            next_s.holdIdx = 2'h0;
            next_s.cnt = 32'h00000000;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s <= SCB_STATE_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    // bus answer comes straight from the state flops
    assign apbRsp = s.rsp;

endmodule

`default_nettype wire

// ===== bench/scb_far_model.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// demodulator feed and trigger source
// ************************************************************
module scb_far_model
(
    input wire logic clock,
    input wire scb_pkg::scb_sample_s srcVal,
    input wire logic trigLow,
    output var scb_pkg::scb_sample_s demodSample,
    output logic externalTriggerInput
);
    import scb_pkg::*;

    // feed registered like a demodulator output; takes the new srcVal on every clock edge
    always_ff @(posedge clock)
    begin
        demodSample <= srcVal;
    end
    // source only pulls low; otherwise the pull-up gives high
    assign externalTriggerInput = trigLow ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

// ===== bench/scb_sample_capture_buffer_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// port checks
// ************************************************************
module scb_sample_capture_buffer_chk
(
    input wire logic clock,
    input wire logic rst_n,
    input wire scb_pkg::scb_apb_req_s apbReq,
    input wire scb_pkg::scb_apb_rsp_s apbRsp,
    input wire scb_pkg::scb_sample_s demodSample,
    input wire logic externalTriggerInput
);
    import scb_pkg::*;
    logic setup;
    logic rdSetup;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // setup cycle decode
    assign setup = apbReq.psel && !apbReq.penable;
    assign rdSetup = setup && !apbReq.pwrite;

    a_ready_after_setup: assert property (setup |=> apbRsp.pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property ($rose(apbRsp.pready) |=> !apbRsp.pready)
        else $error("pready longer than one cycle");
    a_no_ready_idle: assert property (!apbReq.psel [*2] |-> !apbRsp.pready)
        else $error("pready without request");
    a_rsp_hold: assert property (!setup |=> $stable(apbRsp.prdata) && $stable(apbRsp.pslverr))
        else $error("response changed outside setup");
    a_unmapped_err: assert property (setup && apbReq.paddr > 8'h1c |=>
        apbRsp.pslverr && apbRsp.prdata == 32'h0)
        else $error("unmapped access not refused");
    a_ctrl_reads_zero: assert property (rdSetup && apbReq.paddr == SCB_OFS_CTRL |=>
        apbRsp.prdata == 32'h0 && !apbRsp.pslverr)
        else $error("control read not zero");
    a_stat_width: assert property (rdSetup && apbReq.paddr == SCB_OFS_STAT |=>
        apbRsp.prdata[31:3] == 29'h0)
        else $error("state word wider than three bits");
    a_rate_clamp: assert property (rdSetup && apbReq.paddr == SCB_OFS_RATE |=>
        apbRsp.prdata <= 32'h14)
        else $error("rate exponent above limit");
    a_len_even: assert property (rdSetup && apbReq.paddr == SCB_OFS_CFG |=>
        !apbRsp.prdata[0] && apbRsp.prdata[12:0] >= SCB_LEN_MIN &&
        apbRsp.prdata[12:0] <= SCB_LEN_MAX && apbRsp.prdata[15:13] == 3'h0)
        else $error("length out of range or odd");

    // main scenarios reached
    c_launch: cover property (setup && apbReq.pwrite && apbReq.paddr == SCB_OFS_CTRL);
    c_readout: cover property (rdSetup && apbReq.paddr == SCB_OFS_RDDATA);
    c_trig_fall: cover property ($fell(externalTriggerInput));
endmodule

bind scb_sample_capture_buffer scb_sample_capture_buffer_chk i_scb_sample_capture_buffer_chk (
    .clock(clock),
    .rst_n(rst_n),
    .apbReq(apbReq),
    .apbRsp(apbRsp),
    .demodSample(demodSample),
    .externalTriggerInput(externalTriggerInput)
);

`default_nettype wire

// ===== bench/scb_sample_capture_buffer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module scb_sample_capture_buffer_tb_top;
    import scb_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    scb_apb_req_s apbReq = '0;
    scb_apb_rsp_s apbRsp;
    scb_sample_s demodSample;
    scb_sample_s srcVal = '0;
    scb_sample_s oldVal;
    logic extTrig;
    logic trigLow = 1'b0;
    int n_fail = 0;
    int cmp_count = 0;
    logic [33:0] expQ[$];
    logic [33:0] ex;
    logic [31:0] q;
    logic [15:0] lenIn[4] = '{16'd0, 16'd5, 16'd5000, 16'd4095};
    logic [12:0] lenOut[4] = '{13'd2, 13'd6, 13'd4096, 13'd4096};

    // ************************************************************
    // clock, instances
    // ************************************************************
    always #4 clock = ~clock;

    scb_sample_capture_buffer i_scb_sample_capture_buffer (
        .clock(clock),
        .rst_n(rst_n),
        .apbReq(apbReq),
        .apbRsp(apbRsp),
        .demodSample(demodSample),
        .externalTriggerInput(extTrig)
    );

    scb_far_model i_scb_far_model (
        .clock(clock),
        .srcVal(srcVal),
        .trigLow(trigLow),
        .demodSample(demodSample),
        .externalTriggerInput(extTrig)
    );

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // one apb transfer; held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [33:0] e);
        int w;
        @(posedge clock);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        if (!wr)
            expQ.push_back(e);
        @(posedge clock);
        apbReq.penable <= 1'b1;
        w = 0;
        do
        begin
            @(posedge clock);
            w++;
        end
        while (apbRsp.pready !== 1'b1 && w < 50);
        if (w >= 50)
            n_fail++;
        q = apbRsp.prdata;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, '0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {2'b10, e});
    endtask

    task automatic rd_err(input logic [7:0] a);
        apb(1'b0, a, 32'h0, {2'b11, 32'h0});
    endtask

    // poll state word until bit b reads v; a long wait is a mismatch
    task automatic poll(input int b, input logic v);
        int k;
        k = 0;
        do
        begin
            repeat (40) @(posedge clock);
            apb(1'b0, SCB_OFS_STAT, 32'h0, '0);
            k++;
        end
        while (q[b] !== v && k < 800);
        if (k >= 800)
            n_fail++;
    endtask

    task automatic new_val;
        @(posedge clock);
        srcVal <= {$urandom, $urandom, $urandom, $urandom};
        @(posedge clock);
    endtask

    // ************************************************************
    // result monitor
    // ************************************************************
    always @(posedge clock)
    begin
        if (apbReq.psel && apbReq.penable && apbRsp.pready === 1'b1 && !apbReq.pwrite)
        begin
            ex = expQ.pop_front();
            if (ex[33])
            begin
                cmp_count++;
                if ({apbRsp.pslverr, apbRsp.prdata} !== ex[32:0])
                begin
                    n_fail++;
                    $display("[FAIL] %0t got %h exp %h", $time,
                             {apbRsp.pslverr, apbRsp.prdata}, ex[32:0]);
                end
            end
        end
    end

    // watchdog, well above the longest expected run
    initial
    begin
        repeat (95000) @(posedge clock);
        n_fail++;
        give_verdict();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        void'($urandom(11136));
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        // reset values and refusals
        rd(SCB_OFS_CFG, 32'h2);
        rd(SCB_OFS_RATE, 32'h0);
        rd(SCB_OFS_TCPER, 32'h64);
        rd(SCB_OFS_STAT, 32'h0);
        rd(SCB_OFS_CTRL, 32'h0);
        rd_err(8'h20);
        // every selection code with length limits and odd counts
        for (int i = 0; i < 4; i++)
        begin
            wr(SCB_OFS_CFG, {14'h0, 2'(i), lenIn[i]});
            rd(SCB_OFS_CFG, {14'h0, 2'(i), 3'h0, lenOut[i]});
        end
        wr(SCB_OFS_RATE, 32'h1f);
        rd(SCB_OFS_RATE, 32'h14);
        wr(SCB_OFS_RATE, 32'h0);
        wr(SCB_OFS_TCPER, 32'h64);
        // single pass, immediate, all four values per sample
        wr(SCB_OFS_CFG, 32'h30002);
        new_val();
        wr(SCB_OFS_CTRL, 32'h1);
        rd(SCB_OFS_STAT, 32'h3);
        rd_err(SCB_OFS_RDDATA);
        poll(0, 1'b0);
        rd(SCB_OFS_STAT, 32'h6);
        rd(SCB_OFS_PROG, 32'h2);
        oldVal = srcVal;
        new_val();
        repeat (300) @(posedge clock);
        wr(SCB_OFS_RDIDX, 32'h0);
        for (int s = 0; s < 2; s++)
        begin
            rd(SCB_OFS_RDDATA, oldVal.x);
            rd(SCB_OFS_RDDATA, oldVal.y);
            rd(SCB_OFS_RDDATA, oldVal.r);
            rd(SCB_OFS_RDDATA, oldVal.theta);
        end
        wr(SCB_OFS_RDIDX, 32'h1ff);
        rd(SCB_OFS_RDDATA, oldVal.theta);
        // continuous, armed; edges before arming have no effect
        trigLow <= 1'b1;
        repeat (5) @(posedge clock);
        trigLow <= 1'b0;
        rd(SCB_OFS_STAT, 32'h6);
        // two blocks of x,y pairs so a trigger release ends mid-buffer; halt while armed aborts
        wr(SCB_OFS_CFG, 32'h10004);
        wr(SCB_OFS_CTRL, 32'h7);
        wr(SCB_OFS_CTRL, 32'h8);
        trigLow <= 1'b1;
        repeat (5) @(posedge clock);
        trigLow <= 1'b0;
        rd(SCB_OFS_STAT, 32'h0);
        wr(SCB_OFS_CTRL, 32'h7);
        rd(SCB_OFS_STAT, 32'h0);
        trigLow <= 1'b1;
        repeat (4) @(posedge clock);
        rd(SCB_OFS_STAT, 32'h3);
        repeat (3000) @(posedge clock);
        trigLow <= 1'b0;
        poll(0, 1'b0);
        rd(SCB_OFS_STAT, 32'h2);
        rd(SCB_OFS_PROG, 32'h2);
        trigLow <= 1'b1;
        repeat (300) @(posedge clock);
        trigLow <= 1'b0;
        rd(SCB_OFS_STAT, 32'h2);
        wr(SCB_OFS_RDIDX, 32'h0);
        rd(SCB_OFS_RDDATA, srcVal.x);
        rd(SCB_OFS_RDDATA, srcVal.y);
        // continuous immediate until wrap, then halt; one block of all four
        wr(SCB_OFS_CFG, 32'h30002);
        wr(SCB_OFS_CTRL, 32'h3);
        poll(2, 1'b1);
        rd(SCB_OFS_STAT, 32'h7);
        wr(SCB_OFS_CTRL, 32'h8);
        poll(0, 1'b0);
        rd(SCB_OFS_STAT, 32'h6);
        rd(SCB_OFS_PROG, 32'h2);
        wr(SCB_OFS_CTRL, 32'h8);
        rd(SCB_OFS_STAT, 32'h6);
        give_verdict();
    end
endmodule

`default_nettype wire
